// file: ttl_blk_src.sv
// Purpose: Blocking source model driving the stage's blocking pin
// Assumes: Same clock as the stage; the bench says when to block
// Notes: Bench asserts it after the trip has risen, so the blocking comes late
`timescale 1ns/1ps
`default_nettype none
module ttl_blk_src (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic want,
  output logic      block_in
);
  // Launched off the clock edge, like a matrix output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) block_in <= 1'b0;
    else block_in <= want;
  end
endmodule : ttl_blk_src
`default_nettype wire

// file: ttl_pkg.sv
// Purpose: Constants and state type of the thermal stage threshold logic
// Assumes: 125 MHz hclk, AHB-Lite register access, one aligned word per register
// Notes: Temperatures in 0.1 deg (input, curve) or whole deg (linear), k in 0.01
package ttl_pkg;
  localparam int unsigned CLK_NS      = 8;
  localparam int unsigned CYCLE_US    = 5000;
  localparam int unsigned CYCLE_CLKS  = CYCLE_US * 1000 / CLK_NS;
  localparam int unsigned NPTS        = 10;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IX_CTRL = 6'h00;
  localparam logic [5:0] IX_LV1  = 6'h01;
  localparam logic [5:0] IX_LV2  = 6'h02;
  localparam logic [5:0] IX_TDLY = 6'h03;
  localparam logic [5:0] IX_LREF = 6'h04;
  localparam logic [5:0] IX_LMAX = 6'h05;
  localparam logic [5:0] IX_LMIN = 6'h06;
  localparam logic [5:0] IX_STAT = 6'h07;
  localparam logic [5:0] IX_CRV0 = 6'h08;
  // Field positions
  localparam int unsigned F_EN    = 0;
  localparam int unsigned F_CURVE = 1;
  localparam int unsigned F_ENA   = 2;
  localparam int unsigned F_USED  = 6;
  localparam int unsigned F_HI    = 16;
  // Reset values
  localparam logic [11:0] RST_LV_A    = 12'h190;
  localparam logic [11:0] RST_LV_INH  = 12'h320;
  localparam logic [11:0] RST_LV_TRIP = 12'h3e8;
  localparam logic [8:0]  K_ONE       = 9'h064;
  localparam logic [15:0] RST_TREF    = 16'h000f;
  localparam logic [15:0] RST_TMAX    = 16'h002d;
  localparam logic [15:0] RST_TMIN    = 16'h0000;
  localparam logic [15:0] RST_CTEMP   = 16'h0096;

  typedef struct packed {
    logic              en;
    logic              curve;
    logic [3:0]        ena;
    logic [7:0]        used;
    logic [11:0]       lv_a1;
    logic [11:0]       lv_a2;
    logic [11:0]       lv_inh;
    logic [11:0]       lv_trip;
    logic [19:0]       tdly;
    logic [15:0]       tref;
    logic [15:0]       tmax;
    logic [15:0]       tmin;
    logic [8:0]        kmax;
    logic [8:0]        kmin;
    logic [9:0][15:0]  ct;
    logic [9:0][8:0]   ck;
    logic [19:0]       div;
    logic              tick;
    logic              blk_m;
    logic              blk_s;
    logic              blk;
    logic [19:0]       dcnt;
    logic              alarm1;
    logic              alarm2;
    logic              inhibit;
    logic              trip;
    logic              start;
    logic              blocked;
    logic [8:0]        k;
    logic              aph;
    logic              awr;
    logic [5:0]        aidx;
    logic [31:0]       hrdata;
  } ttl_state_s;
endpackage : ttl_pkg

// file: ttl_stage.sv
// Purpose: Ambient correction, thresholds, trip delay and blocking of the thermal stage
// Assumes: Thermal capacity and ambient come from same-clock logic; blocking is a pin
// Notes: Combinational divide for interpolation, traded area for simplicity
`timescale 1ns/1ps
`default_nettype none
module ttl_stage #(
  parameter int unsigned CYCLE_CLKS = ttl_pkg::CYCLE_CLKS
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic signed [15:0] ambient,
  input  wire logic [11:0]        theta,
  input  wire logic               block_in,
  output logic                    alarm1,
  output logic                    alarm2,
  output logic                    inhibit,
  output logic                    trip,
  output logic                    start,
  output logic                    blocked,
  output logic      [8:0]         k_used
);
  ttl_pkg::ttl_state_s s;
  ttl_pkg::ttl_state_s next_s;
  logic                rdy;
  logic                err;

  function automatic int interp(int x, int x0, int x1, int k0, int k1);
    if (x1 <= x0) begin
      return k1;
    end
    return k0 + ((k1 - k0) * (x - x0)) / (x1 - x0);
  endfunction : interp

  logic pickup;
  logic [9:0] act;
  assign act    = {s.used, 2'b11};
  assign pickup = s.en && s.ena[3] && (theta >= s.lv_trip);

  always_comb begin
    int  amb;
    int  tr;
    int  tx;
    int  tn;
    int  kv;
    int  lo;
    int  hi;
    int  first;
    logic lo_f;
    logic hi_f;
    logic [31:0] rd;
    amb   = int'(ambient);
    tr    = 10 * int'($signed(s.tref));
    tx    = 10 * int'($signed(s.tmax));
    tn    = 10 * int'($signed(s.tmin));
    kv    = int'(ttl_pkg::K_ONE);
    lo    = 0;
    hi    = 0;
    first = 0;
    lo_f  = 1'b0;
    hi_f  = 1'b0;
    rd    = 32'h0000_0000;
    next_s = s;

    // Ambient correction, recomputed every cycle so new settings act at once
    if (!s.curve) begin
      if (amb >= tx) begin
        kv = int'(s.kmax);
      end else if (amb <= tn) begin
        kv = int'(s.kmin);
      end else if (amb >= tr) begin
        kv = interp(amb, tr, tx, int'(ttl_pkg::K_ONE), int'(s.kmax));
      end else begin
        kv = interp(amb, tn, tr, int'(s.kmin), int'(ttl_pkg::K_ONE));
      end
    end else begin
      // Points are expected in ascending temperature order
      for (int i = ttl_pkg::NPTS - 1; i >= 0; i--) begin
        if (act[i]) begin
          first = i;
        end
      end
      for (int i = 0; i < ttl_pkg::NPTS; i++) begin
        if (act[i]) begin
          if (amb >= int'($signed(s.ct[i]))) begin
            lo_f = 1'b1;
            lo   = i;
          end else if (!hi_f) begin
            hi_f = 1'b1;
            hi   = i;
          end
        end
      end
      if (!lo_f) begin
        kv = int'(s.ck[first]);
      end else if (!hi_f) begin
        kv = int'(s.ck[lo]);
      end else begin
        kv = interp(amb, int'($signed(s.ct[lo])), int'($signed(s.ct[hi])),
                    int'(s.ck[lo]), int'(s.ck[hi]));
      end
    end
    next_s.k = 9'(kv);

    // Program cycle divider
    next_s.tick = 1'b0;
    if (s.div == 20'(CYCLE_CLKS - 1)) begin
      next_s.div  = 20'h00000;
      next_s.tick = 1'b1;
    end else begin
      next_s.div = s.div + 20'h00001;
    end

    // Pin synchroniser; the synced level is only taken on a cycle start
    next_s.blk_m = block_in;
    next_s.blk_s = s.blk_m;
    if (s.tick) begin
      next_s.blk = s.blk_s;
    end

    // Thresholds, evaluated at each program cycle
    if (s.tick) begin
      next_s.alarm1  = s.en && s.ena[0] && !s.blk && (theta >= s.lv_a1);
      next_s.alarm2  = s.en && s.ena[1] && !s.blk && (theta >= s.lv_a2);
      next_s.inhibit = s.en && s.ena[2] && !s.blk && (theta >= s.lv_inh);
      next_s.blocked = pickup && s.blk;
      if (pickup && !s.blk) begin
        next_s.start = 1'b1;
        if (s.dcnt >= s.tdly) begin
          next_s.trip = 1'b1;
        end else begin
          next_s.dcnt = s.dcnt + 20'h00001;
        end
      end else begin
        // Drop-out and late blocking share the same release path
        next_s.start = 1'b0;
        next_s.trip  = 1'b0;
        next_s.dcnt  = 20'h00000;
      end
    end
    // A cleared enable silences its output without waiting for a cycle
    if (!s.en || !s.ena[0]) begin
      next_s.alarm1 = 1'b0;
    end
    if (!s.en || !s.ena[1]) begin
      next_s.alarm2 = 1'b0;
    end
    if (!s.en || !s.ena[2]) begin
      next_s.inhibit = 1'b0;
    end
    if (!s.en || !s.ena[3]) begin
      next_s.trip    = 1'b0;
      next_s.start   = 1'b0;
      next_s.blocked = 1'b0;
      next_s.dcnt    = 20'h00000;
    end

    // AHB-Lite: address phase capture, write in data phase
    if (hready) begin
      next_s.aph  = hsel && htrans[1];
      next_s.awr  = hwrite;
      next_s.aidx = haddr[7:2];
    end
    if (s.aph && s.awr) begin
      unique case (s.aidx)
        ttl_pkg::IX_CTRL: begin
          next_s.en    = hwdata[ttl_pkg::F_EN];
          next_s.curve = hwdata[ttl_pkg::F_CURVE];
          next_s.ena   = hwdata[ttl_pkg::F_ENA +: 4];
          next_s.used  = hwdata[ttl_pkg::F_USED +: 8];
        end
        ttl_pkg::IX_LV1: begin
          next_s.lv_a1 = hwdata[11:0];
          next_s.lv_a2 = hwdata[ttl_pkg::F_HI +: 12];
        end
        ttl_pkg::IX_LV2: begin
          next_s.lv_inh  = hwdata[11:0];
          next_s.lv_trip = hwdata[ttl_pkg::F_HI +: 12];
        end
        ttl_pkg::IX_TDLY: next_s.tdly = hwdata[19:0];
        ttl_pkg::IX_LREF: next_s.tref = hwdata[15:0];
        ttl_pkg::IX_LMAX: begin
          next_s.tmax = hwdata[15:0];
          next_s.kmax = hwdata[ttl_pkg::F_HI +: 9];
        end
        ttl_pkg::IX_LMIN: begin
          next_s.tmin = hwdata[15:0];
          next_s.kmin = hwdata[ttl_pkg::F_HI +: 9];
        end
        default: begin
          for (int i = 0; i < ttl_pkg::NPTS; i++) begin
            if (s.aidx == ttl_pkg::IX_CRV0 + 6'(i)) begin
              next_s.ct[i] = hwdata[15:0];
              next_s.ck[i] = hwdata[ttl_pkg::F_HI +: 9];
            end
          end
        end
      endcase
    end
    // Read data prepared in the address phase; unmapped reads give zero
    unique case (haddr[7:2])
      ttl_pkg::IX_CTRL: rd = {18'h00000, s.used, s.ena, s.curve, s.en};
      ttl_pkg::IX_LV1:  rd = {4'h0, s.lv_a2, 4'h0, s.lv_a1};
      ttl_pkg::IX_LV2:  rd = {4'h0, s.lv_trip, 4'h0, s.lv_inh};
      ttl_pkg::IX_TDLY: rd = {12'h000, s.tdly};
      ttl_pkg::IX_LREF: rd = {16'h0000, s.tref};
      ttl_pkg::IX_LMAX: rd = {7'h00, s.kmax, s.tmax};
      ttl_pkg::IX_LMIN: rd = {7'h00, s.kmin, s.tmin};
      ttl_pkg::IX_STAT: rd = {9'h000, s.blk, s.blocked, s.start, s.trip, s.inhibit,
                              s.alarm2, s.alarm1, 7'h00, s.k};
      default: begin
        for (int i = 0; i < ttl_pkg::NPTS; i++) begin
          if (haddr[7:2] == ttl_pkg::IX_CRV0 + 6'(i)) begin
            rd = {7'h00, s.ck[i], s.ct[i]};
          end
        end
      end
    endcase
    if (hready && hsel && htrans[1] && !hwrite) begin
      next_s.hrdata = rd;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s         <= '0;
      s.lv_a1   <= ttl_pkg::RST_LV_A;
      s.lv_a2   <= ttl_pkg::RST_LV_A;
      s.lv_inh  <= ttl_pkg::RST_LV_INH;
      s.lv_trip <= ttl_pkg::RST_LV_TRIP;
      s.tref    <= ttl_pkg::RST_TREF;
      s.tmax    <= ttl_pkg::RST_TMAX;
      s.tmin    <= ttl_pkg::RST_TMIN;
      s.kmax    <= ttl_pkg::K_ONE;
      s.kmin    <= ttl_pkg::K_ONE;
      s.k       <= ttl_pkg::K_ONE;
      s.ct      <= {ttl_pkg::NPTS{ttl_pkg::RST_CTEMP}};
      s.ck      <= {ttl_pkg::NPTS{ttl_pkg::K_ONE}};
      rdy       <= 1'b0;
      err       <= 1'b0;
    end else begin
      s   <= next_s;
      rdy <= 1'b1;
      err <= 1'b0;
    end
  end

  assign hrdata    = s.hrdata;
  assign hreadyout = rdy;
  assign hresp     = err;
  assign alarm1    = s.alarm1;
  assign alarm2    = s.alarm2;
  assign inhibit   = s.inhibit;
  assign trip      = s.trip;
  assign start     = s.start;
  assign blocked   = s.blocked;
  assign k_used    = s.k;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_kref;
    !s.curve && (int'(ambient) == 10 * int'($signed(s.tref)))
      && (s.tmin != s.tref) && (s.tmax != s.tref) |=> s.k == ttl_pkg::K_ONE;
  endproperty
  a_kref: assert property (p_kref) else $error("k not 1.00 at reference");

  property p_kmax;
    !s.curve && (int'(ambient) > 10 * int'($signed(s.tmax))) |=> s.k == $past(s.kmax);
  endproperty
  a_kmax: assert property (p_kmax) else $error("k not max-point k");

  property p_kmin;
    !s.curve && (int'(ambient) < 10 * int'($signed(s.tmin)))
      && ($signed(s.tmin) < $signed(s.tmax)) |=> s.k == $past(s.kmin);
  endproperty
  a_kmin: assert property (p_kmin) else $error("k not min-point k");

  property p_klow;
    s.curve && (ambient < $signed(s.ct[0])) && ($signed(s.ct[0]) <= $signed(s.ct[1]))
      |=> s.k == $past(s.ck[0]);
  endproperty
  a_klow: assert property (p_klow) else $error("curve low end k wrong");

  property p_al1;
    s.tick && s.en && s.ena[0] && !s.blk && (theta >= s.lv_a1) |=> alarm1;
  endproperty
  a_al1: assert property (p_al1) else $error("alarm 1 missing");

  property p_off;
    !s.ena[3] |=> !trip && !start;
  endproperty
  a_off: assert property (p_off) else $error("trip while disabled");

  sequence q_go;
    s.tick && pickup && !s.blk && (s.dcnt >= s.tdly);
  endsequence
  property p_trip;
    q_go |=> trip && start;
  endproperty
  a_trip: assert property (p_trip) else $error("trip not raised");

  sequence q_blk;
    s.tick && pickup && s.blk;
  endsequence
  property p_blk;
    q_blk |=> blocked && !start && !trip;
  endproperty
  a_blk: assert property (p_blk) else $error("blocked event processed");

  property p_samp;
    !s.tick |=> $stable(s.blk);
  endproperty
  a_samp: assert property (p_samp) else $error("block taken off cycle");
endmodule : ttl_stage
`default_nettype wire

// file: ttl_stage_tb_top.sv
// Purpose: Register, correction factor, threshold and blocking tests of the stage
// Assumes: Program cycle shortened to 16 clocks
// Notes: Waits of 40 clocks cover sync latency plus two full program cycles (block taken at one, acted on at the next)
`timescale 1ns/1ps
`default_nettype none
module ttl_stage_tb_top;
  localparam int CC = 16;
  logic               hclk = 1'b0;
  logic               hresetn = 1'b0;
  logic               hsel = 1'b0;
  logic        [31:0] haddr = 32'h0;
  logic         [1:0] htrans = 2'h0;
  logic               hwrite = 1'b0;
  logic        [31:0] hwdata = 32'h0;
  logic        [31:0] hrdata;
  logic               hreadyout;
  logic               hresp;
  logic signed [15:0] ambient = 16'sh0000;
  logic        [11:0] theta = 12'h000;
  logic               want = 1'b0;
  logic               block_in;
  logic               alarm1, alarm2, inhibit, trip, start, blocked;
  logic         [8:0] k_used;
  logic        [31:0] q;
  int                 fails = 0;
  int                 num_checks = 0;

  always #4 hclk = ~hclk;

  ttl_stage #(.CYCLE_CLKS(CC)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ambient(ambient), .theta(theta), .block_in(block_in), .alarm1(alarm1),
    .alarm2(alarm2), .inhibit(inhibit), .trip(trip), .start(start),
    .blocked(blocked), .k_used(k_used));
  ttl_blk_src blk (.hclk(hclk), .hresetn(hresetn), .want(want), .block_in(block_in));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // Address phase held until hready, then data phase until hready again
  // Waits are open ended; only the watchdog ends a hung transfer
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
    if (w) @(posedge hclk);
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd

  task automatic amb(input logic [15:0] t, input logic [8:0] e);
    ambient <= t;
    repeat (3) @(posedge hclk);
    chk({23'h0, k_used}, {23'h0, e});
  endtask : amb

  task automatic outs(input logic [11:0] th, input logic [5:0] e);
    theta <= th;
    repeat (40) @(posedge hclk);
    chk({26'h0, alarm1, alarm2, inhibit, trip, start, blocked}, {26'h0, e});
  endtask : outs

  logic [31:0] ra [10] = '{32'h00, 32'h04, 32'h08, 32'h0c, 32'h10, 32'h14, 32'h18,
                           32'h20, 32'h44, 32'hfc};
  logic [31:0] rv [10] = '{32'h0, 32'h0190_0190, 32'h03e8_0320, 32'h0, 32'h0000_000f,
                           32'h0064_002d, 32'h0064_0000, 32'h0064_0096, 32'h0064_0096, 32'h0};
  logic [11:0] tv [7] = '{12'h18f, 12'h190, 12'h1f4, 12'h31f, 12'h320, 12'h3e7, 12'h3e8};
  logic  [5:0] ov [7] = '{6'h00, 6'h20, 6'h30, 6'h30, 6'h38, 6'h38, 6'h3e};

  initial begin
    repeat (50000) @(posedge hclk);
    fails++;
    end_sim();
  end

  initial begin
    repeat (3) @(posedge hclk);
    chk({16'h0, hreadyout, k_used, alarm1, alarm2, inhibit, trip, start, blocked},
        32'h0000_1900);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk({31'h0, hreadyout}, 32'h1);
    for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
    wr(32'hfc, 32'hffff_ffff);
    rd(32'hfc, 32'h0);
    wr(32'h0c, 32'h000a_fc80);
    rd(32'h0c, 32'h000a_fc80);
    wr(32'h0c, 32'h0);
    outs(12'h5dc, 6'h00);
    // Linear: min (0,0.50), ref 15 deg, max (45,2.00)
    wr(32'h14, 32'h00c8_002d);
    wr(32'h18, 32'h0032_0000);
    wr(32'h00, 32'h01);
    amb(16'h0096, 9'h064);
    amb(16'h01f4, 9'h0c8);
    amb(16'hfff6, 9'h032);
    amb(16'h012c, 9'h096);
    amb(16'h004b, 9'h04b);
    // Curve: (0.0,0.50) (10.0,1.50), third point (20.0,2.50) when used
    wr(32'h20, 32'h0032_0000);
    wr(32'h24, 32'h0096_0064);
    wr(32'h28, 32'h00fa_00c8);
    wr(32'h00, 32'h03);
    amb(16'hffce, 9'h032);
    amb(16'h0032, 9'h064);
    amb(16'h01f4, 9'h096);
    wr(32'h00, 32'h43);
    amb(16'h0096, 9'h0c8);
    amb(16'h01f4, 9'h0fa);
    // Thresholds: a1 40.0, a2 50.0, inhibit 80.0, trip 100.0, no delay
    wr(32'h04, 32'h01f4_0190);
    wr(32'h00, 32'h3d);
    for (int i = 0; i < 7; i++) outs(tv[i], ov[i]);
    wr(32'h04, 32'h01f4_04b0);
    outs(12'h3e8, 6'h1e);
    wr(32'h00, 32'h1d);
    // Drop lands on the edge after the write; look once it stands
    @(posedge hclk);
    chk({26'h0, alarm1, alarm2, inhibit, trip, start, blocked}, 32'h18);
    wr(32'h04, 32'h01f4_0190);
    wr(32'h00, 32'h3d);
    outs(12'h3e8, 6'h3e);
    want <= 1'b1;
    outs(12'h3e8, 6'h01);
    rd(32'h1c, 32'h0060_00c8);
    want <= 1'b0;
    outs(12'h3e8, 6'h3e);
    outs(12'h000, 6'h00);
    wr(32'h0c, 32'h2);
    theta <= 12'h3e8;
    while (start !== 1'b1) @(posedge hclk);
    repeat (7) @(posedge hclk);
    chk({31'h0, trip}, 32'h0);
    repeat (16) @(posedge hclk);
    chk({31'h0, trip}, 32'h0);
    repeat (16) @(posedge hclk);
    chk({30'h0, trip, start}, 32'h3);
    end_sim();
  end
endmodule : ttl_stage_tb_top
`default_nettype wire
